//--- verilog/sd_cmd_setup_pkg.sv
/*
 * Constants for the command and transfer setup register bank of the
 * card host: byte offsets, field positions, reset values, codes.
 * Assumes a 32-bit register bus with byte addresses.
 */
package sd_cmd_setup_pkg;

    // Register byte offsets
    localparam logic [11:0] OFS_LENGTH = 12'h0204;
    localparam logic [11:0] OFS_ARG    = 12'h0208;
    localparam logic [11:0] OFS_CMD    = 12'h020C;

    // Reset values
    localparam logic [31:0] RST_LENGTH = 32'h0000_0000;
    localparam logic [31:0] RST_ARG    = 32'h0000_0000;
    localparam logic [31:0] RST_CMD    = 32'h0000_0000;

    // Length register fields
    localparam int COUNT_LSB = 16;
    localparam int SIZE_W    = 11;

    // Command register fields
    localparam int INDEX_LSB = 24;
    localparam int TYPE_LSB  = 22;
    localparam int DP_BIT    = 21;
    localparam int INDEX_CHECK_ENABLE_BIT  = 20;
    localparam int RESPONSE_CRC_CHECK_ENABLE_BIT  = 19;
    localparam int RSP_LSB   = 16;
    localparam int MULTI_BLOCK_SELECT_BIT  = 5;
    localparam int TRANSFER_DIRECTION_BIT  = 4;
    localparam int BCE_BIT   = 1;
    localparam int DE_BIT    = 0;

    // Writable bits; all others read as zero
    localparam logic [31:0] LENGTH_MASK = 32'hFFFF_07FF;
    localparam logic [31:0] CMD_MASK    = 32'h3FFB_0033;

    // Command type codes
    localparam logic [1:0] CTYPE_NORMAL  = 2'h0;
    localparam logic [1:0] CTYPE_SUSPEND = 2'h1;
    localparam logic [1:0] CTYPE_SELECT  = 2'h2;
    localparam logic [1:0] CTYPE_ABORT   = 2'h3;

    // Response kind codes
    localparam logic [1:0] RSP_NONE    = 2'h0;
    localparam logic [1:0] RSP_136     = 2'h1;
    localparam logic [1:0] RSP_48      = 2'h2;
    localparam logic [1:0] RSP_48_BUSY = 2'h3;

    // Documented largest block, bytes
    localparam int MAX_BLOCK_BYTES = 1024;

endpackage : sd_cmd_setup_pkg

//--- verilog/sd_host_command_setup.sv
/*
 * Command and transfer setup registers of a card host controller,
 * reached over a classic Wishbone slave. Holds block length, count,
 * argument, command and transfer mode; launches commands and counts
 * blocks down as card bytes pass.
 * Assumes the card clock and byte strobe arrive unsynchronised, and
 * that the command and data engines take the launch pulse and fields.
 */
`timescale 1ns/1ps
`default_nettype none

module sd_host_command_setup #(
    parameter int MAX_BLOCK_BYTES = sd_cmd_setup_pkg::MAX_BLOCK_BYTES
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    input  wire logic        CLK_EN,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [11:0] WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        CARD_CLK,
    input  wire logic        CARD_BYTE,
    output logic             CMD_START,
    output logic      [5:0]  COMMAND_NUMBER,
    output logic      [31:0] COMMAND_ARGUMENT_VALUE,
    output logic      [1:0]  COMMAND_TYPE,
    output logic      [1:0]  RESPONSE_KIND,
    output logic             INDEX_CHECK_ENABLE,
    output logic             RESPONSE_CRC_CHECK_ENABLE,
    output logic             DATA_PRESENT_SELECT,
    output logic             TRANSFER_DIRECTION,
    output logic             MULTI_BLOCK_SELECT,
    output logic             BLOCK_COUNT_ENABLE,
    output logic             DMA_REQUEST_ENABLE,
    output logic      [10:0] BLOCK_SIZE_BYTES,
    output logic             TRANSFER_BUSY,
    output logic             BLOCK_DONE,
    output logic             TRANSFER_DONE
);

    if (MAX_BLOCK_BYTES < 1 || MAX_BLOCK_BYTES > 2047) begin : g_check
        $error("MAX_BLOCK_BYTES must fit the 11-bit size field");
    end

    localparam logic [10:0] MAX_SIZE = 11'(MAX_BLOCK_BYTES);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } xfer_state_t;

    // Byte-lane merge of a write into a register, masked to its live bits
    function automatic logic [31:0] merge(input logic [31:0] old_val,
                                          input logic [31:0] wdat,
                                          input logic [3:0]  sel,
                                          input logic [31:0] mask);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction : merge

    logic [31:0] length_reg;
    logic [31:0] arg_reg;
    logic [31:0] cmd_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic        start_reg;
    logic        block_done_reg;
    logic        xfer_done_reg;
    xfer_state_t state_reg;
    logic [10:0] byte_cnt_reg;
    logic        clk_s1_reg;
    logic        clk_s2_reg;
    logic        clk_s3_reg;
    logic        byte_s1_reg;
    logic        byte_s2_reg;

    logic        req;
    logic        wr_commit;
    logic        hit_length;
    logic        hit_arg;
    logic        hit_cmd;
    logic        busy;
    logic        launch;
    logic [31:0] cmd_next;
    logic [15:0] count;
    logic [10:0] size;
    logic [10:0] eff_size;
    logic        counted;
    logic        byte_tick;
    logic        block_end;
    logic        last_block;
    logic        has_data;
    logic        stop_cmd;

    assign req        = WB_CYC_I && WB_STB_I;
    // A write lands on the edge where the master sees ack
    assign wr_commit  = CLK_EN && req && WB_WE_I && ack_reg;
    assign hit_length = WB_ADR_I == sd_cmd_setup_pkg::OFS_LENGTH;
    assign hit_arg    = WB_ADR_I == sd_cmd_setup_pkg::OFS_ARG;
    assign hit_cmd    = WB_ADR_I == sd_cmd_setup_pkg::OFS_CMD;
    assign busy       = state_reg == ST_RUN;

    assign count    = length_reg[sd_cmd_setup_pkg::COUNT_LSB +: 16];
    assign size     = length_reg[sd_cmd_setup_pkg::SIZE_W-1:0];
    assign eff_size = (size > MAX_SIZE) ? MAX_SIZE : size;
    assign counted  = cmd_reg[sd_cmd_setup_pkg::MULTI_BLOCK_SELECT_BIT]
                      && cmd_reg[sd_cmd_setup_pkg::BCE_BIT];

    assign cmd_next = merge(cmd_reg, WB_DAT_I, WB_SEL_I, sd_cmd_setup_pkg::CMD_MASK);
    assign launch   = wr_commit && hit_cmd && WB_SEL_I[3];

    assign has_data = cmd_next[sd_cmd_setup_pkg::DP_BIT] && (eff_size != 11'h000)
                      && !(cmd_next[sd_cmd_setup_pkg::MULTI_BLOCK_SELECT_BIT]
                           && cmd_next[sd_cmd_setup_pkg::BCE_BIT]
                           && count == 16'h0000);

    assign stop_cmd = cmd_next[sd_cmd_setup_pkg::TYPE_LSB +: 2] == sd_cmd_setup_pkg::CTYPE_SUSPEND
                      || cmd_next[sd_cmd_setup_pkg::TYPE_LSB +: 2]
                         == sd_cmd_setup_pkg::CTYPE_ABORT;

    assign byte_tick  = busy && clk_s2_reg && !clk_s3_reg && byte_s2_reg;
    assign block_end  = byte_tick && (byte_cnt_reg + 11'h001 == eff_size);
    // uncounted multi-block never ends by itself
    assign last_block = !cmd_reg[sd_cmd_setup_pkg::MULTI_BLOCK_SELECT_BIT]
                        || (counted && count == 16'h0001);

    // Card clock and byte strobe: two flops before any use
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            clk_s1_reg  <= 1'b0;
            clk_s2_reg  <= 1'b0;
            clk_s3_reg  <= 1'b0;
            byte_s1_reg <= 1'b0;
            byte_s2_reg <= 1'b0;
        end else if (CLK_EN) begin
            clk_s1_reg  <= CARD_CLK;
            clk_s2_reg  <= clk_s1_reg;
            clk_s3_reg  <= clk_s2_reg;
            byte_s1_reg <= CARD_BYTE;
            byte_s2_reg <= byte_s1_reg;
        end
    end

    // Bus answer: one ack per request, dropped the cycle after
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else if (CLK_EN) begin
            ack_reg <= req && !ack_reg;
            if (req && !ack_reg) begin
                unique case (1'b1)
                    hit_length: rdata_reg <= length_reg;
                    hit_arg:    rdata_reg <= arg_reg;
                    hit_cmd:    rdata_reg <= cmd_reg;
                    default:    rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Length register: software writes, hardware counts down
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            length_reg <= sd_cmd_setup_pkg::RST_LENGTH;
        end else if (CLK_EN) begin
            if (block_end && counted) begin
                length_reg[sd_cmd_setup_pkg::COUNT_LSB +: 16] <= count - 16'h0001;
            end else if (wr_commit && hit_length && !busy) begin
                length_reg <= merge(length_reg, WB_DAT_I, WB_SEL_I,
                                    sd_cmd_setup_pkg::LENGTH_MASK);
            end
        end
    end

    // Argument register
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            arg_reg <= sd_cmd_setup_pkg::RST_ARG;
        end else if (CLK_EN && wr_commit && hit_arg) begin
            arg_reg <= WB_DAT_I & 32'hFFFF_FFFF;
            for (int i = 0; i < 4; i++) begin
                if (!WB_SEL_I[i]) begin
                    arg_reg[i*8 +: 8] <= arg_reg[i*8 +: 8];
                end
            end
        end
    end

    // Command register: command half always, mode half only when idle
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            cmd_reg <= sd_cmd_setup_pkg::RST_CMD;
        end else if (CLK_EN && wr_commit && hit_cmd) begin
            cmd_reg[31:16] <= cmd_next[31:16];
            if (!busy) begin
                cmd_reg[15:0] <= cmd_next[15:0];
            end
        end
    end

    // Transfer sequencing
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            state_reg     <= ST_IDLE;
            byte_cnt_reg  <= 11'h000;
            xfer_done_reg <= 1'b0;
        end else if (CLK_EN) begin
            xfer_done_reg <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    byte_cnt_reg <= 11'h000;
                    if (launch && cmd_next[sd_cmd_setup_pkg::DP_BIT]) begin
                        if (has_data) begin
                            state_reg <= ST_RUN;
                        end else begin
                            xfer_done_reg <= 1'b1;
                        end
                    end
                end
                ST_RUN: begin
                    if (launch && stop_cmd) begin
                        state_reg     <= ST_IDLE;
                        xfer_done_reg <= 1'b1;
                    end else if (block_end) begin
                        byte_cnt_reg <= 11'h000;
                        if (last_block) begin
                            state_reg     <= ST_IDLE;
                            xfer_done_reg <= 1'b1;
                        end
                    end else if (byte_tick) begin
                        byte_cnt_reg <= byte_cnt_reg + 11'h001;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Event pulses
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            start_reg      <= 1'b0;
            block_done_reg <= 1'b0;
        end else if (CLK_EN) begin
            start_reg      <= launch;
            block_done_reg <= block_end;
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdata_reg;

    assign CMD_START = start_reg;
    assign COMMAND_NUMBER = cmd_reg[sd_cmd_setup_pkg::INDEX_LSB +: 6];
    assign COMMAND_ARGUMENT_VALUE = arg_reg;
    assign COMMAND_TYPE = cmd_reg[sd_cmd_setup_pkg::TYPE_LSB +: 2];
    assign RESPONSE_KIND = cmd_reg[sd_cmd_setup_pkg::RSP_LSB +: 2];
    assign INDEX_CHECK_ENABLE = cmd_reg[sd_cmd_setup_pkg::INDEX_CHECK_ENABLE_BIT];
    assign RESPONSE_CRC_CHECK_ENABLE = cmd_reg[sd_cmd_setup_pkg::RESPONSE_CRC_CHECK_ENABLE_BIT];
    assign DATA_PRESENT_SELECT = cmd_reg[sd_cmd_setup_pkg::DP_BIT];
    assign TRANSFER_DIRECTION = cmd_reg[sd_cmd_setup_pkg::TRANSFER_DIRECTION_BIT];
    assign MULTI_BLOCK_SELECT = cmd_reg[sd_cmd_setup_pkg::MULTI_BLOCK_SELECT_BIT];
    assign BLOCK_COUNT_ENABLE = cmd_reg[sd_cmd_setup_pkg::BCE_BIT];
    assign DMA_REQUEST_ENABLE = cmd_reg[sd_cmd_setup_pkg::DE_BIT];
    assign BLOCK_SIZE_BYTES = size;
    assign TRANSFER_BUSY = busy;
    assign BLOCK_DONE = block_done_reg;
    assign TRANSFER_DONE = xfer_done_reg;

endmodule : sd_host_command_setup

`default_nettype wire

//--- test/setup_properties.sv
/* Concurrent checks on the command setup register bank ports.
   Assumes CLK_EN held high and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module setup_properties (
    input wire logic        SYS_CLK,
    input wire logic        RESET,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [11:0] WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        CMD_START,
    input wire logic [5:0]  COMMAND_NUMBER,
    input wire logic [31:0] COMMAND_ARGUMENT_VALUE,
    input wire logic        DATA_PRESENT_SELECT,
    input wire logic        MULTI_BLOCK_SELECT,
    input wire logic [10:0] BLOCK_SIZE_BYTES,
    input wire logic        TRANSFER_BUSY,
    input wire logic        TRANSFER_DONE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    wire wr = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I;
    logic launch_reg;
    // Write commits at the ack edge, so the pulse is one cycle later
    always_ff @(posedge SYS_CLK) begin
        launch_reg <= !RESET && wr && WB_SEL_I[3] && WB_ADR_I == sd_cmd_setup_pkg::OFS_CMD;
    end
    sequence s_cmd_wr;
        wr && WB_ADR_I == sd_cmd_setup_pkg::OFS_CMD;
    endsequence
    sequence s_launch;
        s_cmd_wr ##0 WB_SEL_I[3];
    endsequence
    a_launch_match: assert property (CMD_START == launch_reg)
        else $error("launch pulse mismatch");
    a_index_sent: assert property (s_launch |=> COMMAND_NUMBER == 6'($past(WB_DAT_I) >> 24))
        else $error("command number mismatch");
    a_arg_frame: assert property (wr && WB_ADR_I == sd_cmd_setup_pkg::OFS_ARG
        && WB_SEL_I == 4'hf |=> COMMAND_ARGUMENT_VALUE == $past(WB_DAT_I))
        else $error("argument mismatch");
    a_size_locked: assert property (TRANSFER_BUSY && wr
        && WB_ADR_I == sd_cmd_setup_pkg::OFS_LENGTH |=> $stable(BLOCK_SIZE_BYTES))
        else $error("size changed while busy");
    a_mode_locked: assert property (TRANSFER_BUSY ##0 s_cmd_wr |=> $stable(MULTI_BLOCK_SELECT))
        else $error("mode changed while busy");
    a_reserved_zero: assert property (WB_ACK_O && !WB_WE_I
        && WB_ADR_I == sd_cmd_setup_pkg::OFS_CMD |-> (WB_DAT_O & ~sd_cmd_setup_pkg::CMD_MASK) == 0)
        else $error("reserved bits not zero");
    a_empty_done: assert property (CMD_START && DATA_PRESENT_SELECT
        && BLOCK_SIZE_BYTES == 11'h000 && !$past(TRANSFER_BUSY) |-> ##[0:2] TRANSFER_DONE)
        else $error("empty transfer not finished");
    a_done_idle: assert property (TRANSFER_DONE |-> !TRANSFER_BUSY ##1 !TRANSFER_DONE)
        else $error("done while busy");
endmodule : setup_properties
bind sd_host_command_setup setup_properties chk_u (
    .SYS_CLK, .RESET, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O, .CMD_START, .COMMAND_NUMBER, .COMMAND_ARGUMENT_VALUE,
    .DATA_PRESENT_SELECT, .MULTI_BLOCK_SELECT, .BLOCK_SIZE_BYTES, .TRANSFER_BUSY,
    .TRANSFER_DONE
);
`default_nettype wire

//--- test/card_model.sv
/* Card side: card clock at 160 ns and the byte strobe.
   Assumes the bench calls send right after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module card_model (
    input wire logic SYS_CLK,
    output var logic CARD_CLK,
    output var logic CARD_BYTE
);
    initial begin
        CARD_CLK = 1'b0;
        CARD_BYTE = 1'b0;
    end
    // Clock stands still between frames; a stalled period moves no byte
    task automatic send(input int n, input bit stall);
        for (int i = 0; i < (stall ? 2 * n : n); i++) begin
            CARD_BYTE <= !(stall && i[0]);
            CARD_CLK <= 1'b1;
            repeat (4) @(posedge SYS_CLK);
            CARD_CLK <= 1'b0;
            repeat (4) @(posedge SYS_CLK);
        end
        CARD_BYTE <= 1'b0;
    endtask : send
endmodule : card_model
`default_nettype wire

//--- test/sd_host_command_setup_test.sv
/* Self-checking bench for the command setup register bank.
   Assumes the card model on the link and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module sd_host_command_setup_test;
    logic        SYS_CLK, RESET, CLK_EN, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
    logic        CARD_CLK, CARD_BYTE, CMD_START, DATA_PRESENT_SELECT, TRANSFER_DIRECTION;
    logic        MULTI_BLOCK_SELECT, BLOCK_COUNT_ENABLE, TRANSFER_BUSY, BLOCK_DONE, TRANSFER_DONE;
    logic [1:0]  COMMAND_TYPE, RESPONSE_KIND;
    logic [3:0]  WB_SEL_I;
    logic [5:0]  COMMAND_NUMBER;
    logic [10:0] BLOCK_SIZE_BYTES;
    logic [11:0] WB_ADR_I, len_a, arg_a, cmd_a;
    logic [31:0] WB_DAT_I, WB_DAT_O, COMMAND_ARGUMENT_VALUE, arg, cmd;
    logic [31:0] exp_q[$];
    int          failures, compares, cycles, blocks, dones, starts, d;

    sd_host_command_setup dut_u (
        .SYS_CLK, .RESET, .CLK_EN, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I,
        .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .CARD_CLK, .CARD_BYTE, .CMD_START, .COMMAND_NUMBER,
        .COMMAND_ARGUMENT_VALUE, .COMMAND_TYPE, .RESPONSE_KIND, .INDEX_CHECK_ENABLE(),
        .RESPONSE_CRC_CHECK_ENABLE(), .DATA_PRESENT_SELECT, .TRANSFER_DIRECTION,
        .MULTI_BLOCK_SELECT, .BLOCK_COUNT_ENABLE, .DMA_REQUEST_ENABLE(), .BLOCK_SIZE_BYTES,
        .TRANSFER_BUSY, .BLOCK_DONE, .TRANSFER_DONE
    );
    card_model card_u (.SYS_CLK, .CARD_CLK, .CARD_BYTE);

    initial begin
        SYS_CLK = 1'b0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    task automatic wb(input logic we, input logic [11:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat);
        @(posedge SYS_CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= adr;
        WB_SEL_I <= sel;
        WB_DAT_I <= dat;
        do @(posedge SYS_CLK); while (WB_ACK_O !== 1'b1);
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
    endtask : wb

    task automatic rd(input logic [11:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        wb(1'b0, adr, 4'hf, 32'h0000_0000);
    endtask : rd

    task automatic until_done(input int n);
        repeat (400) if (dones < n) @(posedge SYS_CLK);
        chk(dones, n);
    endtask : until_done

    // Read data is judged against the oldest note when ack appears
    always @(posedge SYS_CLK) begin
        cycles++;
        blocks += (BLOCK_DONE === 1'b1);
        dones += (TRANSFER_DONE === 1'b1);
        starts += (CMD_START === 1'b1);
        if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0 && exp_q.size() > 0) chk(WB_DAT_O, exp_q.pop_front());
        if (cycles > 20000) begin
            failures++;
            final_report();
        end
    end

    initial begin
        RESET = 1'b1;
        CLK_EN = 1'b1;
        WB_CYC_I = 1'b0;
        WB_STB_I = 1'b0;
        WB_WE_I = 1'b0;
        WB_ADR_I = 12'h000;
        WB_SEL_I = 4'h0;
        WB_DAT_I = 32'h0000_0000;
        len_a = sd_cmd_setup_pkg::OFS_LENGTH;
        arg_a = sd_cmd_setup_pkg::OFS_ARG;
        cmd_a = sd_cmd_setup_pkg::OFS_CMD;
        void'($urandom(32'ha06c));
        arg = $urandom();
        repeat (3) @(posedge SYS_CLK);
        RESET <= 1'b0;
        wb(1'b1, 12'h210, 4'hf, 32'hffff_ffff);
        for (int a = 'h204; a <= 'h210; a += 4) rd(12'(a), 32'h0000_0000);
        wb(1'b1, len_a, 4'hf, 32'hffff_ffff);
        rd(len_a, sd_cmd_setup_pkg::LENGTH_MASK);
        wb(1'b1, cmd_a, 4'h3, 32'hffff_ffff);
        rd(cmd_a, 32'h0000_0033);
        wb(1'b1, arg_a, 4'hf, arg);
        for (int t = 0; t < 4; t++) begin
            cmd = {2'b00, 6'($urandom_range(63)), 2'(t), 4'h0, 2'(3 - t), 16'h0000};
            wb(1'b1, cmd_a, 4'hf, cmd);
            repeat (2) @(posedge SYS_CLK);
            chk(32'(COMMAND_TYPE), 32'(t));
            chk(32'(RESPONSE_KIND), 32'(3 - t));
            chk(32'(COMMAND_NUMBER), 32'(cmd[29:24]));
            chk(COMMAND_ARGUMENT_VALUE, arg);
            chk(starts, t + 1);
        end
        d = dones;
        wb(1'b1, len_a, 4'hf, 32'h0002_0003);
        wb(1'b1, cmd_a, 4'hf, 32'h1222_0032);
        card_u.send(3, 1'b0);
        wb(1'b1, len_a, 4'hf, 32'h0007_0009);
        wb(1'b1, cmd_a, 4'h3, 32'h0000_0000);
        card_u.send(3, 1'b1);
        until_done(d + 1);
        chk(blocks, 2);
        chk(32'(MULTI_BLOCK_SELECT), 32'h1);
        chk(32'(TRANSFER_DIRECTION), 32'h1);
        rd(len_a, 32'h0000_0003);
        for (int k = 0; k < 2; k++) begin
            d = dones;
            wb(1'b1, len_a, 4'hf, k ? 32'h0005_0000 : 32'h0000_0004);
            wb(1'b1, cmd_a, 4'hf, 32'h0120_0022);
            until_done(d + 1);
            chk(blocks, 2);
        end
        wb(1'b1, len_a, 4'hf, 32'h0005_0002);
        wb(1'b1, cmd_a, 4'hf, 32'h0520_0020);
        card_u.send(4, 1'b1);
        chk(blocks, 4);
        chk(32'(TRANSFER_BUSY), 32'h1);
        d = dones;
        wb(1'b1, cmd_a, 4'hf, 32'h3442_0000);
        until_done(d + 1);
        rd(len_a, 32'h0005_0002);
        wb(1'b1, len_a, 4'hf, 32'h0005_0002);
        wb(1'b1, arg_a, 4'hf, arg);
        wb(1'b1, cmd_a, 4'hf, 32'h3482_0000);
        repeat (2) @(posedge SYS_CLK);
        final_report();
    end
endmodule : sd_host_command_setup_test
`default_nettype wire
